//--- tx_waveform_template_ctrl_test.sv
// Purpose: Self-checking bench for the template control register block.
// Assumes: AXI4-Lite master driven by non-blocking assignment after each rising edge.
// Notes: Ready and valid are sampled at the falling edge, where they are settled.

module tx_waveform_template_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [11:0] A_SEL = {txwtc_pkg::IDX_PULSE, 2'b00};
    localparam logic [11:0] A_SCL = {txwtc_pkg::IDX_SCALE, 2'b00};
    localparam logic [11:0] A_ACC = {txwtc_pkg::IDX_ACCESS, 2'b00};
    localparam logic [11:0] A_SMP = {txwtc_pkg::IDX_SAMPLE, 2'b00};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, e1_mode, arb_wave_enable;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, pulse_template_select;
    logic [1:0] bresp, rresp;
    logic [4:0] shaper_index;
    logic [5:0] amp_scale_factor;
    logic signed [8:0] amp_percent;
    logic [6:0] shaper_sample;
    int n_errors = 0;
    int n_compared = 0;

    txwtc_ctrl dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .e1_mode(e1_mode), .shaper_index(shaper_index), .amp_scale_factor(amp_scale_factor),
        .amp_percent(amp_percent), .pulse_template_select(pulse_template_select),
        .arb_wave_enable(arb_wave_enable), .shaper_sample(shaper_sample)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Entry edge first, so a valid released by the last call is never re-raised in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb, got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(negedge aclk);
            ta = arvalid && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
        end
    endtask

    task automatic w(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, {24'h000000, d}, r);
        check({30'h00000000, r}, {30'h00000000, txwtc_pkg::RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, {24'h000000, exp});
        check({30'h00000000, r}, {30'h00000000, txwtc_pkg::RESP_OKAY});
    endtask

    // Shaper read port answers one cycle after the index
    task automatic shp(input logic [4:0] idx, input logic [6:0] exp);
        @(posedge aclk);
        shaper_index <= idx;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check({25'h0000000, shaper_sample}, {25'h0000000, exp});
    endtask

    function automatic int pct(input logic e1, input int code);
        int v;
        v = e1 ? (code - 33) * 3 : (code - 54) * 2;
        if (v < -100) v = -100;
        if (!e1 && v > 20) v = 20;
        if (e1 && v > 100) v = 100;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(A_SCL, 8'h36);
        rd_chk(A_ACC, 8'h00);
        rd_chk(A_SMP, 8'h00);
        rd_chk(A_SEL, 8'h02);
        check({31'h0, arb_wave_enable}, 32'h00000000);
        check({28'h0, pulse_template_select}, 32'h00000002);
        check({26'h0, amp_scale_factor}, 32'h00000036);
        check(32'(amp_percent), 32'h00000000);
    endtask

    task automatic t_scale();
        logic [6:0] tbl [9] = '{7'h36, 7'h37, 7'h3F, 7'h00, 7'h2D, 7'h61, 7'h60, 7'h7F, 7'h40};
        w(A_SCL, 8'hFF);
        rd_chk(A_SCL, 8'h3F);
        foreach (tbl[i]) begin
            @(posedge aclk);
            e1_mode <= tbl[i][6];
            w(A_SCL, {2'b00, tbl[i][5:0]});
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            check({26'h0, amp_scale_factor}, {26'h0, tbl[i][5:0]});
            check(32'(amp_percent), 32'(pct(tbl[i][6], int'(tbl[i][5:0]))));
        end
    endtask

    task automatic t_template();
        w(A_SEL, 8'h08);
        check({31'h0, arb_wave_enable}, 32'h00000001);
        w(A_SEL, 8'h0F);
        check({31'h0, arb_wave_enable}, 32'h00000001);
        check({28'h0, pulse_template_select}, 32'h0000000F);
        w(A_ACC, 8'h43);
        w(A_SMP, 8'h55);
        shp(5'h03, 7'h55);
        w(A_ACC, 8'h59);
        w(A_SMP, 8'h2A);
        shp(5'h1F, 7'h2A);
        shp(5'h13, 7'h2A);
        shp(5'h12, 7'h00);
        w(A_ACC, 8'h63);
        rd_chk(A_SMP, 8'h55);
        rd_chk(A_ACC, 8'h63);
        w(A_ACC, 8'h03);
        rd_chk(A_SMP, 8'h2A);
        w(A_SMP, 8'h11);
        shp(5'h03, 7'h55);
    endtask

    task automatic t_gate();
        w(A_SEL, 8'h07);
        check({31'h0, arb_wave_enable}, 32'h00000000);
        w(A_ACC, 8'h45);
        w(A_SMP, 8'h33);
        shp(5'h05, 7'h00);
        w(A_ACC, 8'h65);
        rd_chk(A_SMP, 8'h33);
        w(A_SMP, 8'hFF);
        rd_chk(A_SMP, 8'h7F);
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h040, 32'h000000A5, r);
        check({30'h0, r}, {30'h0, txwtc_pkg::RESP_SLVERR});
        rd(12'h040, d, r);
        check(d, 32'h00000000);
        check({30'h0, r}, {30'h0, txwtc_pkg::RESP_SLVERR});
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        aresetn = 1'b0;
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        e1_mode = 1'b0;
        shaper_index = 5'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_scale();
        t_template();
        t_gate();
        t_unmapped();
        report_and_stop();
    end
endmodule

//--- txwtc_ctrl.sv
// Purpose: Amplitude scaling and template RAM access registers on AXI4-Lite.
// Assumes: e1_mode and shaper_index come from logic on aclk.
// Notes: Unmapped addresses answer SLVERR, reads of them return zero.
//
// Design decision made here: the AXI4-Lite register port.

module txwtc_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [txwtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [txwtc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [txwtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [txwtc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line mode
    input wire logic e1_mode,
    // Pulse shaper side
    input wire logic [txwtc_pkg::INDEX_W-1:0] shaper_index,
    output logic [txwtc_pkg::SCALE_W-1:0] amp_scale_factor,
    output logic signed [txwtc_pkg::PCT_W-1:0] amp_percent,
    output logic [txwtc_pkg::PULSE_W-1:0] pulse_template_select,
    output logic arb_wave_enable,
    output logic [txwtc_pkg::SAMPLE_W-1:0] shaper_sample
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [3:0] reg_decode(input logic [txwtc_pkg::ADDR_W-1:0] addr);
        logic [txwtc_pkg::ADDR_W-3:0] idx;
        idx = addr[txwtc_pkg::ADDR_W-1:2];
        reg_decode = {idx == txwtc_pkg::IDX_SAMPLE, idx == txwtc_pkg::IDX_ACCESS,
                      idx == txwtc_pkg::IDX_SCALE, idx == txwtc_pkg::IDX_PULSE};
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [txwtc_pkg::ADDR_W-1:0] awaddr_r;
    logic [txwtc_pkg::DATA_W-1:0] wdata_r;
    logic wlane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [txwtc_pkg::DATA_W-1:0] rdata_r;

    logic [txwtc_pkg::PULSE_W-1:0] pulse_sel_r;
    logic [txwtc_pkg::SCALE_W-1:0] amp_scale_r;
    logic acc_en_r;
    logic acc_dir_r;
    logic [txwtc_pkg::INDEX_W-1:0] acc_idx_r;
    logic [txwtc_pkg::SAMPLE_W-1:0] sample_value_r;
    logic signed [txwtc_pkg::PCT_W-1:0] amp_pct_r;

    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [txwtc_pkg::ADDR_W-1:0] wr_addr;
    logic [txwtc_pkg::DATA_W-1:0] wr_data;
    logic wr_lane0;
    logic [3:0] wr_sel;
    logic wr_en;
    logic ar_take;
    logic [3:0] rd_sel;
    logic [txwtc_pkg::DATA_W-1:0] rd_word;

    logic arb_mode;
    logic sel_wr_sample;
    logic sel_wr_access;
    logic ram_we;
    logic [txwtc_pkg::INDEX_W-1:0] ram_waddr;
    logic [txwtc_pkg::SAMPLE_W-1:0] ram_wdata;
    logic [txwtc_pkg::SAMPLE_W-1:0] ram_rd_data;
    logic ram_readback;
    logic [txwtc_pkg::SAMPLE_W-1:0] sample_view;

    logic [txwtc_pkg::SCALE_W-1:0] nom_code;
    logic signed [10:0] step_w;
    logic signed [10:0] hi_w;
    logic signed [10:0] diff_w;
    logic signed [10:0] prod_w;
    logic signed [10:0] pct_w;

    // ----------------------------------------------------------------
    // Write channels
    // ----------------------------------------------------------------
    // Address and data are caught independently, so either may lead
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take);
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_lane0 = w_held_r ? wlane0_r : s_axi_wstrb[0];
    assign wr_sel = reg_decode(wr_addr);
    // Only byte lane 0 holds register bits
    assign wr_en = wr_fire && wr_lane0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wlane0_r <= 1'b0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wlane0_r <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= txwtc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (|wr_sel) ? txwtc_pkg::RESP_OKAY : txwtc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    assign sel_wr_sample = wr_en && wr_sel[txwtc_pkg::SEL_SAMPLE];
    assign sel_wr_access = wr_en && wr_sel[txwtc_pkg::SEL_ACCESS];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_sel_r <= txwtc_pkg::PULSE_RST;
            amp_scale_r <= txwtc_pkg::SCALE_RST; // R1
        end else begin
            if (wr_en && wr_sel[txwtc_pkg::SEL_PULSE]) begin
                pulse_sel_r <= wr_data[txwtc_pkg::PULSE_W-1:0];
            end
            if (wr_en && wr_sel[txwtc_pkg::SEL_SCALE]) begin
                amp_scale_r <= wr_data[txwtc_pkg::SCALE_W-1:0]; // R1
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_en_r <= 1'b0; // R7
            acc_dir_r <= 1'b0; // R8
            acc_idx_r <= txwtc_pkg::INDEX_RST; // R9
        end else if (sel_wr_access) begin
            acc_en_r <= wr_data[txwtc_pkg::ACC_EN_BIT];
            acc_dir_r <= wr_data[txwtc_pkg::ACC_DIR_BIT];
            acc_idx_r <= wr_data[txwtc_pkg::INDEX_W-1:0];
        end
    end

    // Only a software write touches the sample; readback goes around it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_value_r <= txwtc_pkg::SAMPLE_RST; // R10
        end else if (sel_wr_sample) begin
            sample_value_r <= wr_data[txwtc_pkg::SAMPLE_W-1:0]; // R11
        end
    end

    // ----------------------------------------------------------------
    // Template RAM access
    // ----------------------------------------------------------------
    // Top selector bit alone picks the programmable waveform
    assign arb_mode = pulse_sel_r[txwtc_pkg::ARB_BIT]; // R5
    // A write lands either when a sample is written under write access,
    // or when write access is armed, storing the sample already held
    assign ram_we = arb_mode // R6
        && ((sel_wr_sample && acc_en_r && !acc_dir_r) // R7
        || (sel_wr_access && wr_data[txwtc_pkg::ACC_EN_BIT]
            && !wr_data[txwtc_pkg::ACC_DIR_BIT])); // R8
    assign ram_waddr = txwtc_pkg::sample_slot(sel_wr_access ?
        wr_data[txwtc_pkg::INDEX_W-1:0] : acc_idx_r); // R9
    assign ram_wdata = sel_wr_access ? sample_value_r : wr_data[txwtc_pkg::SAMPLE_W-1:0]; // R10
    assign ram_readback = arb_mode && acc_en_r && acc_dir_r; // R12
    assign sample_view = ram_readback ? ram_rd_data : sample_value_r; // R12

    txwtc_tmpl_ram u_ram (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .sw_raddr(acc_idx_r),
        .sw_rdata(ram_rd_data),
        .shp_raddr(shaper_index),
        .shp_rdata(shaper_sample)
    );

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_sel = reg_decode(s_axi_araddr);
    // Reserved bits and unmapped words read zero
    assign rd_word = rd_sel[txwtc_pkg::SEL_PULSE] ? {28'h0000000, pulse_sel_r} :
        rd_sel[txwtc_pkg::SEL_SCALE] ? {26'h0000000, amp_scale_r} : // R1
        rd_sel[txwtc_pkg::SEL_ACCESS] ? {25'h0000000, acc_en_r, acc_dir_r, acc_idx_r} :
        rd_sel[txwtc_pkg::SEL_SAMPLE] ? {25'h0000000, sample_view} : // R12
        32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= txwtc_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= (|rd_sel) ? txwtc_pkg::RESP_OKAY : txwtc_pkg::RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Amplitude percentage
    // ----------------------------------------------------------------
    // Signed offset from nominal; clamped to the mode's span
    assign nom_code = e1_mode ? txwtc_pkg::E1_NOM : txwtc_pkg::T1_NOM; // R3
    assign step_w = e1_mode ? txwtc_pkg::E1_STEP : txwtc_pkg::T1_STEP; // R2
    assign hi_w = e1_mode ? txwtc_pkg::E1_MAX : txwtc_pkg::T1_MAX; // R2
    assign diff_w = $signed({5'h00, amp_scale_r}) - $signed({5'h00, nom_code});
    assign prod_w = diff_w * step_w;
    assign pct_w = (prod_w > hi_w) ? hi_w : // R3
        (prod_w < txwtc_pkg::PCT_MIN) ? txwtc_pkg::PCT_MIN : prod_w; // R2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amp_pct_r <= '0;
        end else begin
            amp_pct_r <= pct_w[txwtc_pkg::PCT_W-1:0];
        end
    end

    assign amp_scale_factor = amp_scale_r;
    assign amp_percent = amp_pct_r;
    assign pulse_template_select = pulse_sel_r;
    assign arb_wave_enable = arb_mode;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_scale_reset: // R1
    assert property (disable iff (1'b0) !aresetn |=> amp_scale_factor == txwtc_pkg::SCALE_RST)
        else $error("scale factor not at reset value");
    chk_scale_write: // R1
    assert property ((wr_en && wr_sel[txwtc_pkg::SEL_SCALE])
        |=> amp_scale_factor == $past(wr_data[txwtc_pkg::SCALE_W-1:0]))
        else $error("scale write not stored");
    chk_t1_step: // R2
    assert property ((!e1_mode && amp_scale_r == txwtc_pkg::T1_NOM + 6'h01)
        |=> amp_percent == txwtc_pkg::T1_STEP[txwtc_pkg::PCT_W-1:0])
        else $error("T1 step above nominal not two percent");
    chk_e1_step: // R3
    assert property ((e1_mode && amp_scale_r == txwtc_pkg::E1_NOM - 6'h01)
        |=> (amp_percent + txwtc_pkg::E1_STEP[txwtc_pkg::PCT_W-1:0]) == 9'h000)
        else $error("E1 step below nominal not three percent");
    chk_arb_gate: // R6
    assert property (ram_we |-> pulse_sel_r[txwtc_pkg::ARB_BIT])
        else $error("RAM written outside arbitrary mode");
    chk_enable_gate: // R7
    assert property ((sel_wr_sample && !acc_en_r) |-> !ram_we)
        else $error("RAM written with access disabled");
    chk_dir_reset: // R8
    assert property (disable iff (1'b0) !aresetn |=> !acc_dir_r && !acc_en_r)
        else $error("access control not cleared by reset");
    chk_index_clamp: // R9
    assert property ((ram_we && sel_wr_access
        && wr_data[txwtc_pkg::INDEX_W-1:0] >= txwtc_pkg::LAST_SAMPLE)
        |-> ram_waddr == txwtc_pkg::LAST_SAMPLE)
        else $error("high sample index not mapped to last slot");
    chk_sample_write: // R10
    assert property (sel_wr_sample
        |=> sample_value_r == $past(wr_data[txwtc_pkg::SAMPLE_W-1:0]))
        else $error("sample write not stored");
    chk_sample_keep: // R11
    assert property (!sel_wr_sample |=> $stable(sample_value_r))
        else $error("sample changed without a write");
    chk_read_back: // R12
    assert property ((ar_take && rd_sel[txwtc_pkg::SEL_SAMPLE] && ram_readback)
        |=> s_axi_rvalid && s_axi_rdata[txwtc_pkg::SAMPLE_W-1:0] == $past(ram_rd_data))
        else $error("read direction does not return RAM sample");

    cov_ram_write: cover property (ram_we);
    cov_ram_read: cover property (ar_take && rd_sel[txwtc_pkg::SEL_SAMPLE] && ram_readback);
    cov_e1_nominal: cover property (e1_mode && amp_scale_r == txwtc_pkg::E1_NOM);
    cov_unmapped: cover property (s_axi_bvalid && s_axi_bresp == txwtc_pkg::RESP_SLVERR);

endmodule

//--- txwtc_pkg.sv
// Purpose: Constants for the transmit waveform template control block.
// Assumes: Single channel, AXI4-Lite with 32-bit data, 12-bit byte address.
// Notes: Register byte address is four times the register index.
//
// Behaviour
// (R1) The scaling register keeps a six-bit amplitude factor in bits 5..0, bits 7..6 read zero, reset 0x36.
// (R2) In T1/J1 mode code 110110 is nominal and each step is 2 percent, limited to +20 and -100 percent.
// (R3) In E1 mode code 100001 is nominal and each step is 3 percent, limited to +100 and -100 percent.
// (R4) Software should write 100001 to the scaling field when the channel runs in E1 mode.
// (R5) A pulse template selector with its top bit set picks the programmable waveform, lower bits ignored.
// (R6) Access enable, direction, index and sample value act only while the selector matches 1XXX.
// (R7) Bit 6 of the access register enables template RAM access, reset zero.
// (R8) Bit 5 of the access register picks direction, zero writes and one reads, reset zero.
// (R9) Bits 4..0 give the sample index, codes 19 to 31 all map to sample 19, reset zero.
// (R10) Bits 6..0 of the sample register hold the seven-bit sample for the indexed RAM slot, bit 7 zero.
// (R11) The sample register changes only when software writes it.
// (R12) In read direction with access enabled, the RAM sample at the index reads back through the sample register.

package txwtc_pkg;

    // ----------------------------------------------------------------
    // Bus
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [9:0] IDX_PULSE = 10'h006;
    localparam logic [9:0] IDX_SCALE = 10'h007;
    localparam logic [9:0] IDX_ACCESS = 10'h008;
    localparam logic [9:0] IDX_SAMPLE = 10'h009;
    localparam int SEL_PULSE = 0;
    localparam int SEL_SCALE = 1;
    localparam int SEL_ACCESS = 2;
    localparam int SEL_SAMPLE = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Fields and resets
    // ----------------------------------------------------------------
    localparam int SCALE_W = 6;
    localparam int PULSE_W = 4;
    localparam int INDEX_W = 5;
    localparam int SAMPLE_W = 7;
    localparam int PCT_W = 9;
    localparam int ARB_BIT = 3;
    localparam int ACC_EN_BIT = 6;
    localparam int ACC_DIR_BIT = 5;
    localparam logic [SCALE_W-1:0] SCALE_RST = 6'h36;
    localparam logic [PULSE_W-1:0] PULSE_RST = 4'h2;
    localparam logic [INDEX_W-1:0] INDEX_RST = 5'h00;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 7'h00;

    // ----------------------------------------------------------------
    // Amplitude scaling
    // ----------------------------------------------------------------
    localparam logic [SCALE_W-1:0] T1_NOM = 6'h36;
    localparam logic [SCALE_W-1:0] E1_NOM = 6'h21;
    localparam logic signed [10:0] T1_STEP = 11'h002;
    localparam logic signed [10:0] E1_STEP = 11'h003;
    localparam logic signed [10:0] T1_MAX = 11'h014;
    localparam logic signed [10:0] E1_MAX = 11'h064;
    localparam logic signed [10:0] PCT_MIN = 11'h79C;

    // ----------------------------------------------------------------
    // Template RAM
    // ----------------------------------------------------------------
    localparam int RAM_DEPTH = 20;
    localparam logic [INDEX_W-1:0] LAST_SAMPLE = 5'h13;

    function automatic logic [INDEX_W-1:0] sample_slot(input logic [INDEX_W-1:0] idx);
        sample_slot = (idx > LAST_SAMPLE) ? LAST_SAMPLE : idx;
    endfunction

endpackage

//--- txwtc_tmpl_ram.sv
// Purpose: Twenty-entry template sample store with two read ports.
// Assumes: Indices already arrive from the aclk domain.
// Notes: Cleared by reset so readback is never undefined.

module txwtc_tmpl_ram (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write port
    input wire logic we,
    input wire logic [txwtc_pkg::INDEX_W-1:0] waddr,
    input wire logic [txwtc_pkg::SAMPLE_W-1:0] wdata,
    // Software read port
    input wire logic [txwtc_pkg::INDEX_W-1:0] sw_raddr,
    output logic [txwtc_pkg::SAMPLE_W-1:0] sw_rdata,
    // Pulse shaper read port
    input wire logic [txwtc_pkg::INDEX_W-1:0] shp_raddr,
    output logic [txwtc_pkg::SAMPLE_W-1:0] shp_rdata
);

    logic [txwtc_pkg::SAMPLE_W-1:0] mem [0:txwtc_pkg::RAM_DEPTH-1];
    logic [txwtc_pkg::INDEX_W-1:0] shp_slot;
    logic [txwtc_pkg::SAMPLE_W-1:0] shp_rdata_r;

    genvar i;
    generate
        for (i = 0; i < txwtc_pkg::RAM_DEPTH; i = i + 1) begin : g_entry
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mem[i] <= txwtc_pkg::SAMPLE_RST;
                end else if (we && int'(waddr) == i) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    // Index clamp keeps the array reads in range
    assign sw_rdata = mem[txwtc_pkg::sample_slot(sw_raddr)]; // R9
    assign shp_slot = txwtc_pkg::sample_slot(shp_raddr); // R9

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shp_rdata_r <= txwtc_pkg::SAMPLE_RST;
        end else begin
            shp_rdata_r <= mem[shp_slot];
        end
    end

    assign shp_rdata = shp_rdata_r;

endmodule
